// file: design/drs_pkg.sv
// Summary of operation
// RQ1 - Low pulses under 5us are ignored; pulses over 9us always cause full reset.
// RQ2 - Short spikes inside an accepted reset pulse are filtered the same way; the code rejects only a one-cycle high while held, two cycles release.
// RQ3 - After release, stored settings are reloaded from NVM, starting within 5ms; in sleep-out mode loading waits for drs_blank to end.
// RQ4 - Display blanks during reset; sleep-out reset runs blanking up to 120ms.
// RQ5 - Release completes within 5ms from sleep-in, 120ms from sleep-out; in sleep-out mode the 120ms count starts only after drs_blank ends.
// RQ6 - Host waits at least 5ms after release before any command.
// RQ7 - Host sends no sleep-out command until 120ms after release.
// RQ8 - Low time is counted on the internal clock; count clears when line returns high.
package drs_pkg;
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned REJECT_US = 5;
  localparam int unsigned ACCEPT_US = 9;
  localparam int unsigned LOAD_START_MS = 5;
  localparam int unsigned SLEEP_IN_RELEASE_MS = 5;
  localparam int unsigned SLEEP_OUT_RELEASE_MS = 120;
  localparam int unsigned BLANK_MAX_MS = 120;
  // Acceptance sits between the two limits: 7us, safely inside the undefined band.
  localparam int unsigned ACCEPT_CYCLES = (REJECT_US + ACCEPT_US) * CLOCK_MHZ / 2;
  localparam int unsigned LOAD_START_CYCLES = LOAD_START_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned SLEEP_IN_CYCLES = SLEEP_IN_RELEASE_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned SLEEP_OUT_CYCLES = SLEEP_OUT_RELEASE_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned BLANK_CYCLES = BLANK_MAX_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned CNT_W = 26;

  typedef enum {drs_run, drs_blank, drs_held, drs_load, drs_wait} drs_state_t;

  typedef struct packed {
    logic in_reset;
    logic blank;
    logic loading;
    logic ready;
  } drs_status_t;
endpackage

// file: design/drs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer #(
  parameter int unsigned ACCEPT_CYCLES = drs_pkg::ACCEPT_CYCLES,
  parameter int unsigned BLANK_CYCLES = drs_pkg::BLANK_CYCLES,
  parameter int unsigned LOAD_START_CYCLES = drs_pkg::LOAD_START_CYCLES,
  parameter int unsigned SLEEP_IN_CYCLES = drs_pkg::SLEEP_IN_CYCLES,
  parameter int unsigned SLEEP_OUT_CYCLES = drs_pkg::SLEEP_OUT_CYCLES,
  parameter int unsigned LOAD_CYCLES = 64
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hw_reset_n,
  input wire logic sleep_out_mode,
  input wire logic nvm_done,
  output drs_pkg::drs_status_t status,
  output logic nvm_load_start
);
  localparam int W = drs_pkg::CNT_W;
  logic [2:0] sync;
  logic [2:0] next_sync;
  logic next_line_lo;
  logic line_lo;
  logic [W-1:0] low_cnt;
  logic [W-1:0] next_low_cnt;
  logic [W-1:0] tmr;
  logic [W-1:0] next_tmr;
  logic [W-1:0] limit;
  logic [W-1:0] next_limit;
  logic low_ok;
  logic held_sleep_out;
  logic next_held_sleep_out;
  drs_pkg::drs_state_t state;
  drs_pkg::drs_state_t next_state;
  drs_pkg::drs_status_t next_status;
  logic next_nvm_load_start;

  // A change on the pin counts once the second and third stages agree.
  // Three stages cost a cycle of latency but keep a metastable first stage
  // away from the agreement test.
  always_comb
  begin
    next_sync = {sync[1:0], hw_reset_n};
    next_line_lo = line_lo;
    if (sync[1] == sync[2])
    begin
      next_line_lo = ~sync[2]; // see RQ2
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync <= 3'h7;
      line_lo <= 1'b0;
    end
    else
    begin
      sync <= next_sync;
      line_lo <= next_line_lo;
    end
  end

  // Low time is counted; any high on the filtered line clears it, so spikes never accumulate.
  always_comb
  begin
    next_low_cnt = low_cnt; // see RQ8
    if (!line_lo)
    begin
      next_low_cnt = '0; // see RQ8
    end
    else if (low_cnt < W'(ACCEPT_CYCLES))
    begin
      next_low_cnt = low_cnt + W'(1);
    end
  end
  assign low_ok = (low_cnt >= W'(ACCEPT_CYCLES)); // see RQ1

  // The counter has its own register group so the filter stays separable.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      low_cnt <= '0;
    end
    else
    begin
      low_cnt <= next_low_cnt;
    end
  end

  always_comb
  begin
    next_state = state;
    next_tmr = tmr;
    next_limit = limit;
    next_held_sleep_out = held_sleep_out;
    next_nvm_load_start = 1'b0;
    unique case (state)
      drs_pkg::drs_run:
      begin
        if (low_ok) // see RQ1
        begin
          next_held_sleep_out = sleep_out_mode;
          next_tmr = '0;
          // Sleep-out needs the panel driven dark first; sleep-in is already dark.
          if (sleep_out_mode)
          begin
            next_state = drs_pkg::drs_blank; // see RQ4
          end
          else
          begin
            next_state = drs_pkg::drs_held; // see RQ4
          end
        end
      end
      drs_pkg::drs_blank:
      begin
        next_tmr = tmr + W'(1);
        if (tmr + W'(1) >= W'(BLANK_CYCLES))
        begin
          next_state = drs_pkg::drs_held; // see RQ4
        end
      end
      drs_pkg::drs_held:
      begin
        // A one-cycle high spike while held never reaches the filtered line; release
        // happens as soon as the second and third stages agree high.
        if (!line_lo) // see RQ2
        begin
          next_tmr = '0;
          if (held_sleep_out)
          begin
            next_limit = W'(SLEEP_OUT_CYCLES); // see RQ5
          end
          else
          begin
            next_limit = W'(SLEEP_IN_CYCLES); // see RQ5
          end
          next_nvm_load_start = 1'b1; // see RQ3
          next_state = drs_pkg::drs_load;
        end
      end
      drs_pkg::drs_load:
      begin
        next_tmr = tmr + W'(1);
        if (low_ok)
        begin
          next_tmr = '0;
          next_state = drs_pkg::drs_held;
        end
        else if (tmr + W'(1) >= W'(LOAD_START_CYCLES))
        begin
          // Loading must not outlive its start window even if the store hangs.
          next_state = drs_pkg::drs_wait; // see RQ3
        end
        else if (nvm_done || tmr + W'(1) >= W'(LOAD_CYCLES))
        begin
          next_state = drs_pkg::drs_wait; // see RQ3
        end
      end
      drs_pkg::drs_wait:
      begin
        next_tmr = tmr + W'(1);
        if (low_ok)
        begin
          next_tmr = '0;
          next_state = drs_pkg::drs_held;
        end
        else if (tmr + W'(1) >= limit)
        begin
          next_state = drs_pkg::drs_run; // see RQ5
        end
      end
    endcase
  end

  // Outputs follow the next state so they change on the same edge as the state.
  always_comb
  begin
    next_status.in_reset = (next_state != drs_pkg::drs_run);
    next_status.blank = (next_state == drs_pkg::drs_blank) || (next_state == drs_pkg::drs_held);
    next_status.loading = (next_state == drs_pkg::drs_load);
    next_status.ready = (next_state == drs_pkg::drs_run);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tmr <= '0;
      limit <= '0;
      held_sleep_out <= 1'b0;
      state <= drs_pkg::drs_run;
    end
    else
    begin
      tmr <= next_tmr;
      limit <= next_limit;
      held_sleep_out <= next_held_sleep_out;
      state <= next_state;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      status <= '{in_reset: 1'b0, blank: 1'b0, loading: 1'b0, ready: 1'b1};
      nvm_load_start <= 1'b0;
    end
    else
    begin
      status <= next_status;
      nvm_load_start <= next_nvm_load_start;
    end
  end
endmodule // drs_sequencer
`default_nettype wire

// file: testbench/drs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module drs_chk #(parameter int unsigned ACCEPT_CYCLES = 20) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hw_reset_n,
  input wire logic sleep_out_mode,
  input wire logic nvm_done,
  input wire drs_pkg::drs_status_t status,
  input wire logic nvm_load_start
);
  int unsigned low = 0;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock)
    low <= hw_reset_n ? 0 : low + 1;
  sequence spike_s;
    (status.blank && !hw_reset_n) ##1 hw_reset_n ##1 !hw_reset_n [*6];
  endsequence
  accept_min_a: assert property ($rose(status.in_reset) |-> low >= ACCEPT_CYCLES)
    else $error("early accept");
  spike_hold_a: assert property (spike_s |-> status.in_reset && !status.loading)
    else $error("spike released");
  load_pulse_a: assert property (nvm_load_start |-> hw_reset_n ##1 !nvm_load_start)
    else $error("bad load start");
  blank_on_a: assert property ($rose(status.in_reset) |-> status.blank)
    else $error("no blank");
  ready_clean_a: assert property (status.ready |-> !status.in_reset && !status.blank)
    else $error("ready in reset");
  ready_bound_a: assert property ($rose(status.loading) |-> ##[1:1000] status.ready)
    else $error("slow release");
  count_clear_a: assert property (hw_reset_n [*8] |=> !$rose(status.in_reset))
    else $error("stale count");
endmodule // drs_chk
bind drs_sequencer drs_chk #(.ACCEPT_CYCLES(ACCEPT_CYCLES)) i_drs_chk (.clock(clock),
  .rst(rst), .hw_reset_n(hw_reset_n), .sleep_out_mode(sleep_out_mode),
  .nvm_done(nvm_done), .status(status), .nvm_load_start(nvm_load_start));
`default_nettype wire

// file: testbench/drs_host.sv
`timescale 1ns/1ps
`default_nettype none
module drs_host (
  input wire logic clock,
  output logic hw_reset_n
);
  initial hw_reset_n = 1'b1;
  // The spike sits mid-pulse so both halves alone outlast acceptance.
  task automatic pulse(input int n, input bit spike);
    hw_reset_n = 1'b0;
    repeat (n / 2) @(negedge clock);
    hw_reset_n = spike;
    @(negedge clock);
    hw_reset_n = 1'b0;
    repeat (n / 2) @(negedge clock);
    hw_reset_n = 1'b1;
  endtask
endmodule // drs_host
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b0;
  logic done = 1'b0;
  wire logic pin;
  drs_pkg::drs_status_t st;
  logic ld;
  int fail_count = 0;
  int check_count = 0;
  int ld_n = 0;
  always #2.5 clock = ~clock;
  always @(negedge clock)
    if (ld === 1'b1)
      ld_n++;
  drs_host i_drs_host (.clock(clock), .hw_reset_n(pin));
  drs_sequencer #(.ACCEPT_CYCLES(20), .BLANK_CYCLES(200),
    .SLEEP_IN_CYCLES(100), .SLEEP_OUT_CYCLES(300), .LOAD_CYCLES(16)) i_drs_sequencer (
    .clock(clock), .rst(rst), .hw_reset_n(pin), .sleep_out_mode(mode),
    .nvm_done(done), .status(st), .nvm_load_start(ld));
  task automatic chk(input string s, input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", s, exp, seen);
    end
  endtask
  task automatic wt(input logic [3:0] v, input int n);
    for (int k = 0; k < n && st !== v; k++) @(negedge clock);
    chk("state", st, v);
  endtask
  task automatic t_short;
    i_drs_host.pulse(10, 1'b0);
    repeat (30) @(negedge clock);
    chk("short", st, 4'h1);
  endtask
  task automatic t_in;
    fork i_drs_host.pulse(60, 1'b1); join_none
    repeat (28) @(negedge clock);
    chk("held", st, 4'hc);
    repeat (6) @(negedge clock);
    chk("spike", st, 4'hc);
    wt(4'ha, 40);
    wt(4'h1, 126);
    chk("load start", 4'(ld_n), 4'h1);
  endtask
  task automatic t_out;
    mode = 1'b1;
    done = 1'b1;
    fork i_drs_host.pulse(40, 1'b0); join_none
    repeat (30) @(negedge clock);
    chk("blank", st, 4'hc);
    repeat (150) @(negedge clock);
    chk("blank run", st, 4'hc);
    wt(4'h1, 400);
    chk("load again", 4'(ld_n), 4'h2);
  endtask
  task automatic finish_test;
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #10000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    t_short();
    t_in();
    t_out();
    finish_test();
  end
endmodule // tb
`default_nettype wire
